// File: testbench/bridge_vga_decode_pm_cap_test.sv
// self-checking bench for bridge control, legacy video decode and power management
`include "bridge_vga_regs.svh"
module bridge_vga_decode_pm_cap_test
  import bridge_vga_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, ce, mem_en, io_en, store_fwd, hot_reset;
  logic [1:0] power_state, ps;
  logic [1:0] ps_seq [5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h1};
  fwd_req_s   fwd_req;
  fwd_rsp_s   fwd_rsp;
  cfg_req_s   cfg_req;
  cfg_rsp_s   cfg_rsp;
  load_req_s  load_req;
  int         bad_count, samples_checked;

  bridge_vga_decode_pm_cap i_bridge_vga_decode_pm_cap (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .CFG_REQ(cfg_req), .CFG_RSP(cfg_rsp),
    .LOAD_REQ(load_req), .MEM_ACCESS_EN(mem_en), .IO_ACCESS_EN(io_en), .FWD_REQ(fwd_req),
    .FWD_RSP(fwd_rsp), .STORE_FWD(store_fwd), .HOT_RESET(hot_reset), .POWER_STATE(power_state));
  rc_cfg_model i_rc_cfg_model (.clk(clk), .cfg_rsp(cfg_rsp), .cfg_req(cfg_req),
    .load_req(load_req));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    i_rc_cfg_model.access(1'b0, a, 4'hF, 32'h0, d, ok);
    check("read ack", {31'h0, ok}, 32'h1);
    check("read data", d, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic        ok;
    i_rc_cfg_model.access(1'b1, a, be, wd, d, ok);
    check("write ack", {31'h0, ok}, 32'h1);
    check("write data", d, 32'h0);
  endtask : wr
  // expected {fwd_down, fwd_up, vga_claim, vga_block}, one cycle after the request
  task automatic fwd(input logic io, input logic prim, input logic win, input logic [31:0] a,
                     input logic [3:0] exp);
    @(negedge clk);
    fwd_req = '{valid: 1'b1, is_io: io, from_primary: prim, win_hit: win, addr: a};
    @(negedge clk);
    check("forward", {28'h0, fwd_rsp}, {28'h0, exp});
    fwd_req.valid = 1'b0;
  endtask : fwd
  task automatic results();
    $display("checked %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // about 120 cycles are needed; the margin is wide
  initial begin
    #100000;
    bad_count++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    mem_en = 1'b0;
    io_en = 1'b0;
    fwd_req = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rd(`OFS_BRIDGE_CTRL, 32'h0000_0100);
    rd(`OFS_PM_CAP, 32'hC803_4801);
    rd(`OFS_PM_STAT_CTRL, 32'h0000_0008);
    rd(8'h48, 32'h0);
    check("power_state", {30'h0, power_state}, 32'h0);
    $display("test reset values done");
    wr(`OFS_BRIDGE_CTRL, 4'hF, 32'hFFFF_FFFF);
    rd(`OFS_BRIDGE_CTRL, 32'h005F_01FF);
    check("store_fwd", {31'h0, store_fwd}, 32'h1);
    check("hot_reset", {31'h0, hot_reset}, 32'h1);
    wr(`OFS_BRIDGE_CTRL, 4'h4, 32'h0008_0000);
    rd(`OFS_BRIDGE_CTRL, 32'h0008_01FF);
    check("hot_reset", {31'h0, hot_reset}, 32'h0);
    $display("test bridge control done");
    mem_en = 1'b1;
    io_en = 1'b1;
    fwd(1'b0, 1'b1, 1'b0, 32'h000A_0000, 4'hA);
    fwd(1'b0, 1'b1, 1'b0, 32'h000B_FFFF, 4'hA);
    fwd(1'b0, 1'b1, 1'b0, 32'h000C_0000, 4'h0);
    fwd(1'b0, 1'b1, 1'b0, 32'h0009_FFFF, 4'h0);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03B0, 4'hA);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03BB, 4'hA);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03BC, 4'h0);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03C0, 4'hA);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03DF, 4'hA);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_FBB0, 4'hA);
    fwd(1'b1, 1'b1, 1'b0, 32'h0001_03B0, 4'h0);
    fwd(1'b0, 1'b0, 1'b1, 32'h000A_0000, 4'h1);
    fwd(1'b1, 1'b0, 1'b1, 32'h0000_03C0, 4'h1);
    mem_en = 1'b0;
    fwd(1'b0, 1'b1, 1'b1, 32'h000A_0000, 4'h0);
    mem_en = 1'b1;
    io_en = 1'b0;
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03B0, 4'h0);
    io_en = 1'b1;
    wr(`OFS_BRIDGE_CTRL, 4'h4, 32'h0018_0000);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_FBB0, 4'h0);
    fwd(1'b1, 1'b1, 1'b0, 32'h0000_03B0, 4'hA);
    wr(`OFS_BRIDGE_CTRL, 4'h4, 32'h0);
    fwd(1'b0, 1'b1, 1'b0, 32'h000A_0000, 4'h0);
    fwd(1'b0, 1'b1, 1'b1, 32'h000A_0000, 4'h8);
    fwd(1'b0, 1'b0, 1'b1, 32'h000A_0000, 4'h4);
    check("store_fwd", {31'h0, store_fwd}, 32'h0);
    $display("test forwarding done");
    ps = 2'h0;
    foreach (ps_seq[i]) begin
      wr(`OFS_PM_STAT_CTRL, 4'h1, {30'h0, ps_seq[i]});
      if (ps_seq[i] == 2'h0 || ps_seq[i] == 2'h3)
        ps = ps_seq[i];
      rd(`OFS_PM_STAT_CTRL, {28'h0, 2'h2, ps});
      check("power_state", {30'h0, power_state}, {30'h0, ps});
    end
    $display("test power state done");
    i_rc_cfg_model.load(`OFS_PM_CAP, 32'hC803_5001);
    rd(`OFS_PM_CAP, 32'hC803_5001);
    i_rc_cfg_model.load(`OFS_PM_STAT_CTRL, 32'h2);
    rd(`OFS_PM_STAT_CTRL, 32'h8);
    i_rc_cfg_model.load(`OFS_PM_STAT_CTRL, 32'h3);
    rd(`OFS_PM_STAT_CTRL, 32'hB);
    $display("test preload done");
    ce = 1'b0;
    i_rc_cfg_model.load(`OFS_BRIDGE_CTRL, 32'h0040_0000);
    ce = 1'b1;
    rd(`OFS_BRIDGE_CTRL, 32'h0000_01FF);
    check("hot_reset", {31'h0, hot_reset}, 32'h0);
    i_rc_cfg_model.load(`OFS_BRIDGE_CTRL, 32'h0040_0000);
    rd(`OFS_BRIDGE_CTRL, 32'h0040_0000);
    check("hot_reset", {31'h0, hot_reset}, 32'h1);
    $display("test clock enable done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(`OFS_PM_STAT_CTRL, 32'h8);
    check("power_state", {30'h0, power_state}, 32'h0);
    rd(`OFS_BRIDGE_CTRL, 32'h0000_0100);
    check("hot_reset", {31'h0, hot_reset}, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule : bridge_vga_decode_pm_cap_test

// File: testbench/bridge_vga_monitor.sv
// concurrent checks on the ports of the bridge control and power management block
`include "bridge_vga_regs.svh"
module bridge_vga_monitor
  import bridge_vga_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CE,
  input wire cfg_req_s   CFG_REQ,
  input wire cfg_rsp_s   CFG_RSP,
  input wire load_req_s  LOAD_REQ,
  input wire logic       MEM_ACCESS_EN,
  input wire logic       IO_ACCESS_EN,
  input wire fwd_req_s   FWD_REQ,
  input wire fwd_rsp_s   FWD_RSP,
  input wire logic       STORE_FWD,
  input wire logic       HOT_RESET,
  input wire logic [1:0] POWER_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // decoded requests
  // ----
  // a loader write in the same cycle wins, so those cycles are left out
  wire logic cfg_wr = CE && CFG_REQ.wr && !LOAD_REQ.wr;
  wire logic bc_wr  = cfg_wr && CFG_REQ.addr == `OFS_BRIDGE_CTRL && CFG_REQ.be[2];
  wire logic ps_wr  = cfg_wr && CFG_REQ.addr == `OFS_PM_STAT_CTRL && CFG_REQ.be[0];
  wire logic ps_bad = ps_wr && (CFG_REQ.wdata[1:0] == 2'h1 || CFG_REQ.wdata[1:0] == 2'h2);
  wire logic rd_bc  = CE && CFG_REQ.rd && CFG_REQ.addr == `OFS_BRIDGE_CTRL;
  wire logic rd_cap = CE && CFG_REQ.rd && CFG_REQ.addr == `OFS_PM_CAP;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_bad_ps_acked: assert property (ps_bad |=> CFG_RSP.ack)
    else $error("unsupported power state write not acknowledged");
  a_bad_ps_kept: assert property (ps_bad |-> ##2 $stable(POWER_STATE))
    else $error("unsupported power state write changed the state");
  a_ps_accept: assert property (ps_wr && !ps_bad
    |-> ##2 POWER_STATE == $past(CFG_REQ.wdata[1:0], 2))
    else $error("power state write not taken");
  a_ps_legal: assert property (POWER_STATE != 2'h1 && POWER_STATE != 2'h2)
    else $error("power state shows an unsupported encoding");
  a_bc_rsvd_zero: assert property (rd_bc
    |=> CFG_RSP.rdata[31:23] == 9'h0 && !CFG_RSP.rdata[21])
    else $error("unsupported bridge control bits read nonzero");
  a_pm_fixed_zero: assert property (rd_cap
    |=> CFG_RSP.rdata[20:19] == 2'h0 && CFG_RSP.rdata[26:25] == 2'h0)
    else $error("clock or d1 d2 support bits read nonzero");
  a_vga_store_fwd: assert property (bc_wr |-> ##2 STORE_FWD == $past(CFG_REQ.wdata[19], 2))
    else $error("store and forward does not follow video enable");
  a_sbr_hot_reset: assert property (bc_wr |-> ##2 HOT_RESET == $past(CFG_REQ.wdata[22], 2))
    else $error("hot reset does not follow secondary bus reset");
  a_claim_cause: assert property (FWD_RSP.vga_claim |-> FWD_RSP.fwd_down && $past(FWD_REQ.valid
    && FWD_REQ.from_primary && (FWD_REQ.is_io ? IO_ACCESS_EN : MEM_ACCESS_EN)))
    else $error("video claim without enabled primary request");
  a_block_up: assert property (FWD_RSP.vga_block |-> !FWD_RSP.fwd_up
    && $past(FWD_REQ.valid && !FWD_REQ.from_primary))
    else $error("video address passed upstream");
  a_io_upper_zero: assert property (FWD_RSP.vga_claim && $past(FWD_REQ.is_io)
    |-> $past(FWD_REQ.addr[31:16]) == 16'h0)
    else $error("video io claim above first 64 KB");
endmodule : bridge_vga_monitor

bind bridge_vga_decode_pm_cap bridge_vga_monitor i_bridge_vga_monitor (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP),
  .LOAD_REQ(LOAD_REQ), .MEM_ACCESS_EN(MEM_ACCESS_EN), .IO_ACCESS_EN(IO_ACCESS_EN),
  .FWD_REQ(FWD_REQ), .FWD_RSP(FWD_RSP), .STORE_FWD(STORE_FWD), .HOT_RESET(HOT_RESET),
  .POWER_STATE(POWER_STATE));

// File: testbench/rc_cfg_model.sv
// root complex and serial preload model driving the configuration ports
module rc_cfg_model
  import bridge_vga_pkg::*;
(
  input  wire logic     clk,
  input  wire cfg_rsp_s cfg_rsp,
  output cfg_req_s      cfg_req,
  output load_req_s     load_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_req = '0;
    load_req = '0;
  end
  // one-cycle request pulse; the answer stands only in the next cycle
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
    @(negedge clk);
    cfg_req = '{wr: wr, rd: !wr, addr: addr, be: be, wdata: wdata};
    @(negedge clk);
    ok = cfg_rsp.ack;
    rdata = cfg_rsp.rdata;
    cfg_req = '0;
  endtask : access
  // whole dword as the loader image holds it; aux current is kept zero by the caller
  task automatic load(input logic [7:0] addr, input logic [31:0] wdata);
    @(negedge clk);
    load_req = '{wr: 1'b1, addr: addr, wdata: wdata};
    @(negedge clk);
    load_req = '0;
  endtask : load
endmodule : rc_cfg_model

// File: verilog/bridge_vga_decode_pm_cap.sv
// bridge control upper half, legacy video decode and power management capability
//
// Function
// R01 - vga enable claims primary memory requests in A0000-BFFFF and forwards them down
// R02 - vga enable forwards io with zero upper half, low bits in video ranges
// R03 - 16-bit decode bit, reset zero, picks 10 or 16 bit io decode
// R04 - vga enable blocks legacy video addresses going upstream
// R05 - legacy forwarding ignores base/limit windows and the isa enable bit
// R06 - memory needs memory enable, io needs io enable to forward
// R07 - vga enable resets to zero; when clear only windows forward
// R08 - egress port with vga enable uses store-and-forward, not cut-through
// R09 - secondary bus reset bit drives hot reset on downstream link
// R10 - unsupported bridge control bits and top reserved bits read zero
// R11 - capability header gives id one and next pointer to msi structure
// R12 - version field reads three by default
// R13 - pme clock bit always reads zero
// R14 - device-specific initialization bit reads zero by default
// R15 - loader should program auxiliary current to zero
// R16 - pme support defaults with bits 31, 30, 27 set; d1, d2 zero
// R17 - two-bit power state reports and accepts state, resets to d0
// R18 - writes of d1 or d2 complete but leave power state unchanged
`include "bridge_vga_regs.svh"
module bridge_vga_decode_pm_cap
  import bridge_vga_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic      CLK,
  input  wire logic      RST_N,
  input  wire logic      CE,
  input  wire cfg_req_s  CFG_REQ,
  output cfg_rsp_s       CFG_RSP,
  input  wire load_req_s LOAD_REQ,
  input  wire logic      MEM_ACCESS_EN,
  input  wire logic      IO_ACCESS_EN,
  input  wire fwd_req_s  FWD_REQ,
  output fwd_rsp_s       FWD_RSP,
  output logic           STORE_FWD,
  output logic           HOT_RESET,
  output logic [1:0]     POWER_STATE
);

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  generate
    if (ADDR_W != 32) begin : g_bad_width
      $error("bridge_vga_decode_pm_cap supports only 32-bit addresses");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // one offset compare shared by both write ports and the read mux
  function automatic logic at_ofs(input logic [7:0] addr, input logic [7:0] ofs);
    at_ofs = (addr == ofs);
  endfunction : at_ofs

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] int_line;
  logic [7:0] int_pin;
  logic       parity_resp;
  logic       serr_en;
  logic       isa_en;
  logic       vga_en;
  logic       vga_16bit;
  logic       sec_bus_reset;
  logic [7:0] cap_id;
  logic [7:0] next_ptr;
  logic [2:0] pm_version;
  logic       dsi;
  logic [2:0] aux_current;
  logic [4:0] pme_support;
  logic [1:0] power_state;

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  wire logic        cfg_wr_bc;
  wire logic        cfg_wr_ps;
  wire logic        ld_wr_bc;
  wire logic        ld_wr_cap;
  wire logic        ld_wr_ps;
  wire logic        cfg_b0_bc;
  wire logic        cfg_b2_bc;
  wire logic [1:0]  new_ps;
  wire logic        ps_write;
  wire logic        ps_ok;
  wire logic [31:0] ld_d;
  wire logic [31:0] cfg_d;
  wire logic        sel_bc;
  wire logic        sel_cap;
  wire logic        sel_ps;

  assign sel_bc    = at_ofs(CFG_REQ.addr, `OFS_BRIDGE_CTRL);
  assign sel_cap   = at_ofs(CFG_REQ.addr, `OFS_PM_CAP);
  assign sel_ps    = at_ofs(CFG_REQ.addr, `OFS_PM_STAT_CTRL);

  assign ld_d      = LOAD_REQ.wdata;
  assign cfg_d     = CFG_REQ.wdata;
  assign cfg_wr_bc = CFG_REQ.wr && sel_bc;
  assign cfg_wr_ps = CFG_REQ.wr && sel_ps && CFG_REQ.be[0];
  assign cfg_b0_bc = cfg_wr_bc && CFG_REQ.be[0];
  assign cfg_b2_bc = cfg_wr_bc && CFG_REQ.be[2];
  assign ld_wr_bc  = LOAD_REQ.wr && at_ofs(LOAD_REQ.addr, `OFS_BRIDGE_CTRL);
  assign ld_wr_cap = LOAD_REQ.wr && at_ofs(LOAD_REQ.addr, `OFS_PM_CAP);
  assign ld_wr_ps  = LOAD_REQ.wr && at_ofs(LOAD_REQ.addr, `OFS_PM_STAT_CTRL);

  // ----------------------------------------------------------------------
  // power state decode
  // ----------------------------------------------------------------------
  // loader wins when both sources write the power state in one cycle
  assign ps_write  = ld_wr_ps || cfg_wr_ps;
  assign new_ps    = ld_wr_ps ? ld_d[1:0] : cfg_d[1:0];
  // intermediate states are dropped silently; the write still completes
  assign ps_ok     = (new_ps == `PS_D0) || (new_ps == `PS_D3HOT); // R18

  // ----------------------------------------------------------------------
  // bridge control and interrupt signal
  // ----------------------------------------------------------------------
  // the loader writes the whole dword and wins over a config write
  wire logic        line_we;
  wire logic        ctrl_we;
  wire logic [31:0] bc_src;

  assign line_we = ld_wr_bc || cfg_b0_bc;
  assign ctrl_we = ld_wr_bc || cfg_b2_bc;
  assign bc_src  = ld_wr_bc ? ld_d : cfg_d;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_line <= `RST_INT_LINE;
    end else if (CE && line_we) begin
      int_line <= bc_src[7:0];
    end
  end

  // only 00h and 01h are legal pin values
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_pin <= `RST_INT_PIN;
    end else if (CE && ld_wr_bc) begin
      int_pin <= {7'h00, ld_d[8]};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      parity_resp   <= 1'b0;
      serr_en       <= 1'b0;
      isa_en        <= 1'b0;
      vga_en        <= 1'b0; // R07
      vga_16bit     <= 1'b0; // R03
      sec_bus_reset <= 1'b0;
    end else if (CE && ctrl_we) begin
      parity_resp   <= bc_src[`BIT_PARITY_RESP];
      serr_en       <= bc_src[`BIT_SERR_EN];
      isa_en        <= bc_src[`BIT_ISA_EN];
      vga_en        <= bc_src[`BIT_VGA_EN];
      vga_16bit     <= bc_src[`BIT_VGA_16BIT];
      sec_bus_reset <= bc_src[`BIT_SEC_BUS_RESET]; // R09
    end
  end

  // ----------------------------------------------------------------------
  // power management capability, loader only
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_id      <= `RST_CAP_ID; // R11
      next_ptr    <= `RST_NEXT_PTR; // R11
      pm_version  <= `RST_PM_VERSION; // R12
      dsi         <= `RST_DSI; // R14
      aux_current <= `RST_AUX_CURRENT; // R15
      pme_support <= `RST_PME_SUPPORT; // R16
    end else if (CE && ld_wr_cap) begin
      cap_id      <= ld_d[7:0];
      next_ptr    <= ld_d[15:8];
      pm_version  <= ld_d[18:16];
      dsi         <= ld_d[21];
      // a loader is expected to keep this at zero
      aux_current <= ld_d[24:22]; // R15
      pme_support <= ld_d[31:27];
    end
  end

  // ----------------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      power_state <= `RST_POWER_STATE; // R17
    end else if (CE && ps_write && ps_ok) begin
      power_state <= new_ps; // R17
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  wire logic [31:0] rd_bc;
  wire logic [31:0] rd_cap;
  wire logic [31:0] rd_ps;
  wire logic [31:0] rd_mux;
  wire logic        next_ack;
  wire logic [31:0] next_rdata;

  // bits 21, 23-31 are hardwired zero
  assign rd_bc  = {4'h0,
                   4'h0,
                   1'b0,
                   sec_bus_reset,
                   1'b0,
                   vga_16bit,
                   vga_en,
                   isa_en,
                   serr_en,
                   parity_resp,
                   int_pin,
                   int_line}; // R10
  // pme clock, d1 and d2 support read zero
  assign rd_cap = {pme_support,
                   2'h0,
                   aux_current,
                   dsi,
                   1'b0,
                   1'b0,
                   pm_version,
                   next_ptr,
                   cap_id}; // R13
  assign rd_ps  = {28'h0000000,
                   `RST_NO_SOFT_RESET,
                   1'b0,
                   power_state}; // R17
  assign rd_mux = sel_bc  ? rd_bc  :
                  sel_cap ? rd_cap :
                  sel_ps  ? rd_ps  :
                  32'h0000_0000;

  // every request seen with CE high is answered one cycle later; unmapped reads give zero
  assign next_ack   = CFG_REQ.wr || CFG_REQ.rd;
  assign next_rdata = CFG_REQ.rd ? rd_mux : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RSP <= '0;
    end else if (CE) begin
      CFG_RSP.ack   <= next_ack;
      CFG_RSP.rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // forwarding decision
  // ----------------------------------------------------------------------
  fwd_rsp_s dec_rsp;

  vga_decode u_decode (
    .req       (FWD_REQ),
    .vga_en    (vga_en),
    .vga_16bit (vga_16bit),
    .mem_en    (MEM_ACCESS_EN),
    .io_en     (IO_ACCESS_EN),
    .rsp       (dec_rsp)
  );

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FWD_RSP <= '0;
    end else if (CE) begin
      FWD_RSP <= dec_rsp; // R01
    end
  end

  // cut-through cannot be used while legacy video is routed here
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      STORE_FWD <= 1'b0;
    end else if (CE) begin
      STORE_FWD <= vga_en; // R08
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HOT_RESET <= 1'b0;
    end else if (CE) begin
      HOT_RESET <= sec_bus_reset; // R09
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      POWER_STATE <= `RST_POWER_STATE;
    end else if (CE) begin
      POWER_STATE <= power_state; // R17
    end
  end

endmodule : bridge_vga_decode_pm_cap

// File: verilog/bridge_vga_pkg.sv
// types shared by the bridge port configuration logic
package bridge_vga_pkg;

  // ----------------------------------------------------------------------
  // configuration access from the root complex
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cfg_rsp_s;

  // ----------------------------------------------------------------------
  // preload from serial eeprom or i2c
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } load_req_s;

  // ----------------------------------------------------------------------
  // transaction presented for a forwarding decision
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        from_primary;
    logic        win_hit;
    logic [31:0] addr;
  } fwd_req_s;

  typedef struct packed {
    logic fwd_down;
    logic fwd_up;
    logic vga_claim;
    logic vga_block;
  } fwd_rsp_s;

  function automatic logic in_range32(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
    in_range32 = (a >= lo) && (a <= hi);
  endfunction : in_range32

  function automatic logic in_range10(input logic [9:0] a,
                                      input logic [9:0] lo,
                                      input logic [9:0] hi);
    in_range10 = (a >= lo) && (a <= hi);
  endfunction : in_range10

endpackage : bridge_vga_pkg

// File: verilog/bridge_vga_regs.svh
// register offsets, field positions and reset values of the bridge port
`ifndef BRIDGE_VGA_REGS_SVH
`define BRIDGE_VGA_REGS_SVH

// ----------------------------------------------------------------------
// offsets (byte addresses, dword aligned)
// ----------------------------------------------------------------------
`define OFS_BRIDGE_CTRL      8'h3C
`define OFS_PM_CAP           8'h40
`define OFS_PM_STAT_CTRL     8'h44

// ----------------------------------------------------------------------
// bridge control field positions
// ----------------------------------------------------------------------
`define BIT_PARITY_RESP      16
`define BIT_SERR_EN          17
`define BIT_ISA_EN           18
`define BIT_VGA_EN           19
`define BIT_VGA_16BIT        20
`define BIT_SEC_BUS_RESET    22

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_INT_LINE         8'h00
`define RST_INT_PIN          8'h01
`define RST_CAP_ID           8'h01
`define RST_NEXT_PTR         8'h48
`define RST_PM_VERSION       3'h3
`define RST_DSI              1'b0
`define RST_AUX_CURRENT      3'h0
`define RST_PME_SUPPORT      5'h19
`define RST_POWER_STATE      2'h0
`define RST_NO_SOFT_RESET    1'b1

// ----------------------------------------------------------------------
// power state encodings
// ----------------------------------------------------------------------
`define PS_D0                2'h0
`define PS_D3HOT             2'h3

// ----------------------------------------------------------------------
// legacy video windows
// ----------------------------------------------------------------------
`define VGA_MEM_LO           32'h000A_0000
`define VGA_MEM_HI           32'h000B_FFFF
`define VGA_IO_A_LO          10'h3B0
`define VGA_IO_A_HI          10'h3BB
`define VGA_IO_B_LO          10'h3C0
`define VGA_IO_B_HI          10'h3DF

`endif

// File: verilog/vga_decode.sv
// legacy video address decoder, combinational
`include "bridge_vga_regs.svh"
module vga_decode
  import bridge_vga_pkg::*;
(
  input  wire fwd_req_s req,
  input  wire logic     vga_en,
  input  wire logic     vga_16bit,
  input  wire logic     mem_en,
  input  wire logic     io_en,
  output fwd_rsp_s      rsp
);

  // ----------------------------------------------------------------------
  // address match
  // ----------------------------------------------------------------------
  wire logic mem_hit;
  wire logic io_low_hit;
  wire logic io_alias_ok;
  wire logic io_hit;
  wire logic vga_hit;
  wire logic access_ok;
  wire logic claim;
  wire logic block;

  assign mem_hit     = !req.is_io && in_range32(req.addr, `VGA_MEM_LO, `VGA_MEM_HI); // R01
  assign io_low_hit  = in_range10(req.addr[9:0], `VGA_IO_A_LO, `VGA_IO_A_HI)
                    || in_range10(req.addr[9:0], `VGA_IO_B_LO, `VGA_IO_B_HI); // R02
  // aliases pass in 10-bit mode, only the first alias in 16-bit mode
  assign io_alias_ok = !vga_16bit || (req.addr[15:10] == 6'h00); // R03
  assign io_hit      = req.is_io && (req.addr[31:16] == 16'h0000)
                    && io_low_hit && io_alias_ok; // R02
  assign vga_hit     = vga_en && (mem_hit || io_hit);
  assign access_ok   = req.is_io ? io_en : mem_en; // R06

  // ----------------------------------------------------------------------
  // decision
  // ----------------------------------------------------------------------
  // windows and isa enable are not consulted for the legacy hit
  assign claim = req.valid && req.from_primary && vga_hit && access_ok; // R05
  assign block = req.valid && !req.from_primary && vga_hit; // R04

  assign rsp.vga_claim = claim;
  assign rsp.vga_block = block;
  assign rsp.fwd_down  = claim || (req.valid && req.from_primary && req.win_hit
                                   && access_ok); // R07
  assign rsp.fwd_up    = req.valid && !req.from_primary && req.win_hit && !block; // R04

endmodule : vga_decode
